// ---- rpd_ctrl_model.sv ----
// Reply controller model: starts a reply, then drives one pulse level per slot.
// Assumes the decoder counts slots of SLOT_CYC cycles from the start pulse.
module rpd_ctrl_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [15:0] pat,
  input wire logic [7:0] oba_val,
  output logic init_pulse,
  output rpd_pkg::rpd_slot_type dly_slot,
  output logic undly_pulse,
  output logic [7:0] undly_oba
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc;
  int slot;
  logic run;
  // Start pulse, then slot counting; pulse present for marked slots only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run <= 1'b0;
      cyc <= 0;
      slot <= 0;
      init_pulse <= 1'b0;
      dly_slot <= '0;
    end
    else
    begin
      init_pulse <= start && !run;
      if (start && !run)
      begin
        run <= 1'b1;
        cyc <= 0;
        slot <= 0;
      end
      else if (run)
      begin
        cyc <= (cyc == rpd_pkg::SLOT_CYC - 1) ? 0 : cyc + 1;
        if (cyc == rpd_pkg::SLOT_CYC - 1)
          slot <= slot + 1;
        if (slot > 16)
          run <= 1'b0;
      end
      // Every value equals the reference, so the average stays put
      dly_slot.pulse <= run && slot >= 1 && slot <= 16 && pat[slot-1];
      dly_slot.sls <= 1'b0;
      dly_slot.oba <= oba_val;
    end
  end
  assign undly_pulse = 1'b0;
  assign undly_oba = oba_val;
endmodule

// ---- rpd_datapath.sv ----
// Reply pulse decoder datapath: slot decode, code/confidence, averaging, words.
// Assumes pulse, flag and value inputs come from logic on pclk; APB from host.
//
// Our own choices: the address map and the APB interface to the registers.
module rpd_datapath (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic paddr_dummy_unused_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic init_pulse,
  input wire logic ref_sel_last,
  input wire logic ref_sidelobe,
  input wire logic mil_ident,
  input wire logic data_reset,
  input wire rpd_pkg::rpd_slot_type dly_slot,
  input wire logic [rpd_pkg::OBA_W-1:0] undly_oba,
  input wire logic undly_pulse,
  input wire logic [rpd_pkg::OBA_W-1:0] ref_value,
  input wire logic [2:0] other_garble,
  input wire logic [2:0] other_corr,
  input wire logic last_code_slot,
  input wire logic [1:0] word_sel,
  input wire logic word_en,
  output logic [15:0] word_out,
  output logic own_corr,
  output logic undly_corr,
  output logic busy,
  output logic reply_ready,
  output logic last_code_phantom
);
  // Internal state
  rpd_pkg::rpd_state_type state_reg;
  logic [rpd_pkg::RING_STAGES-1:0] ring_reg;
  logic [15:0] slot_cnt_reg;
  logic [15:0] life_cnt_reg;
  logic [rpd_pkg::CODE_BITS-1:0] code_reg;
  logic [rpd_pkg::CODE_BITS-1:0] conf_reg;
  logic [rpd_pkg::CNT_W-1:0] count_reg;
  logic [rpd_pkg::OBA_W-1:0] ref_reg;
  logic [rpd_pkg::OBA_W-1:0] avg_reg;
  logic [rpd_pkg::SUM_W-1:0] sum_reg;
  logic [rpd_pkg::ZERO_WIN-1:0] hist_reg;
  logic [rpd_pkg::OBA_W-1:0] thresh_reg;
  logic first_slot_reg;
  logic slot_tick;
  logic run;
  logic any_window;
  logic one_conf;
  logic zero_conf;
  logic bit_val;
  logic bit_conf;
  logic dly_corr_c;
  logic undly_corr_c;
  logic [rpd_pkg::OBA_W:0] avg_sum;
  logic [rpd_pkg::OBA_W-1:0] diff_d;
  logic [rpd_pkg::OBA_W-1:0] diff_u;
  logic [15:0] w3;
  logic [15:0] w4;
  logic apb_wr;
  logic apb_rd;

  assign run = (state_reg == rpd_pkg::RPD_RUN);
  // Slot strobe at each 181-cycle (1.448 us) step after the first framing pulse
  assign slot_tick = run && (slot_cnt_reg == 16'(rpd_pkg::SLOT_CYC - 1));

  // Sequencer: init starts, end of interval stops, data reset clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= rpd_pkg::RPD_IDLE;
    else if (data_reset)
      state_reg <= rpd_pkg::RPD_IDLE;
    else
      case (state_reg)
        rpd_pkg::RPD_IDLE:
        begin
          if (init_pulse)
            state_reg <= rpd_pkg::RPD_RUN;
        end
        rpd_pkg::RPD_RUN:
        begin
          if (life_cnt_reg == 16'(rpd_pkg::REPLY_CYC - 1))
            state_reg <= rpd_pkg::RPD_DONE;
        end
        rpd_pkg::RPD_DONE: state_reg <= rpd_pkg::RPD_DONE;
        default: state_reg <= rpd_pkg::RPD_IDLE;
      endcase
  end

  // Twelve-stage ring counter, slot and interval counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ring_reg <= '0;
      slot_cnt_reg <= 16'h0000;
      life_cnt_reg <= 16'h0000;
    end
    else if (data_reset || !run)
    begin
      ring_reg <= (state_reg == rpd_pkg::RPD_IDLE && init_pulse && !data_reset)
        ? 12'h001 : 12'h000;
      slot_cnt_reg <= 16'h0000;
      life_cnt_reg <= 16'h0000;
    end
    else
    begin
      ring_reg <= {ring_reg[rpd_pkg::RING_STAGES-2:0], ring_reg[rpd_pkg::RING_STAGES-1]};
      slot_cnt_reg <= slot_tick ? 16'h0000 : slot_cnt_reg + 16'h0001;
      life_cnt_reg <= life_cnt_reg + 16'h0001;
    end
  end

  // Propagation history of pulses for zero decode window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hist_reg <= '0;
    else
      hist_reg <= {hist_reg[rpd_pkg::ZERO_WIN-2:0], dly_slot.pulse};
  end

  // Elements nominal+1, nominal, nominal-1, nominal-2 seen together
  assign any_window = dly_slot.pulse | (|hist_reg[rpd_pkg::ZERO_WIN-2:0]);
  // One is confident if not sidelobe, not garbled unless correlated, and no other channel correlated
  assign one_conf = !dly_slot.sls && (!(|other_garble) || own_corr) && !(|other_corr);
  assign zero_conf = !any_window;
  assign bit_val = dly_slot.pulse;
  assign bit_conf = bit_val ? one_conf : zero_conf;

  // Code and confidence shift registers, held after the interval
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_reg <= '0;
      conf_reg <= '0;
    end
    else if (data_reset)
    begin
      code_reg <= '0;
      conf_reg <= '0;
    end
    else if (slot_tick)
    begin
      code_reg <= {code_reg[rpd_pkg::CODE_BITS-2:0], bit_val};
      conf_reg <= {conf_reg[rpd_pkg::CODE_BITS-2:0], bit_conf};
    end
  end

  // First slot flag marks the reference pulse reaching the code register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_slot_reg <= 1'b0;
    else if (state_reg == rpd_pkg::RPD_IDLE)
      first_slot_reg <= 1'b1;
    else if (slot_tick)
      first_slot_reg <= 1'b0;
  end

  // Count confident ones, inhibited on the reference slot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= '0;
    else if (data_reset)
      count_reg <= '0;
    else if (slot_tick && bit_val && bit_conf && !first_slot_reg
             && count_reg != 4'hF)
      count_reg <= count_reg + 4'h1;
  end

  // Reference register, running average and sum
  assign avg_sum = {1'b0, avg_reg} + {1'b0, dly_slot.oba};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_reg <= '0;
      avg_reg <= '0;
      sum_reg <= '0;
    end
    else if (data_reset)
    begin
      ref_reg <= '0;
      avg_reg <= '0;
      sum_reg <= '0;
    end
    else if (state_reg == rpd_pkg::RPD_IDLE && init_pulse)
    begin
      ref_reg <= ref_value;
      avg_reg <= ref_value;
      sum_reg <= rpd_pkg::SUM_W'(ref_value);
    end
    else if (slot_tick && bit_val && !first_slot_reg)
    begin
      avg_reg <= avg_sum[rpd_pkg::OBA_W:1];
      sum_reg <= sum_reg + rpd_pkg::SUM_W'(dly_slot.oba);
    end
  end

  // Correlators against the running average
  assign diff_d = (dly_slot.oba > avg_reg) ? dly_slot.oba - avg_reg : avg_reg - dly_slot.oba;
  assign diff_u = (undly_oba > avg_reg) ? undly_oba - avg_reg : avg_reg - undly_oba;
  assign dly_corr_c = run && dly_slot.pulse && (diff_d <= thresh_reg);
  assign undly_corr_c = run && undly_pulse && (diff_u <= thresh_reg);

  // Registered correlation and flag outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      own_corr <= 1'b0;
      undly_corr <= 1'b0;
      last_code_phantom <= 1'b0;
      busy <= 1'b0;
      reply_ready <= 1'b0;
    end
    else
    begin
      own_corr <= dly_corr_c;
      undly_corr <= undly_corr_c;
      last_code_phantom <= undly_corr_c && last_code_slot;
      busy <= !data_reset && (run || (state_reg == rpd_pkg::RPD_IDLE && init_pulse)
                || state_reg == rpd_pkg::RPD_DONE);
      reply_ready <= !data_reset && (state_reg == rpd_pkg::RPD_DONE);
    end
  end

  // Output words
  assign w3 = {4'h0, (count_reg >= rpd_pkg::CNT_TWO), ref_sel_last, ref_sidelobe, mil_ident,
               avg_reg};
  assign w4 = {count_reg, sum_reg};

  // Word multiplexer stepped by the assembler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      word_out <= 16'h0000;
    else if (!word_en)
      word_out <= 16'h0000;
    else
      case (word_sel)
        2'h0: word_out <= code_reg;
        2'h1: word_out <= conf_reg;
        2'h2: word_out <= w3;
        2'h3: word_out <= w4;
        default: word_out <= 16'h0000;
      endcase
  end

  // APB slave: zero-wait, threshold writable, words and status readable
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      thresh_reg <= rpd_pkg::THRESH_RST;
    else if (apb_wr && paddr == rpd_pkg::OFF_CTRL)
      thresh_reg <= pwdata[rpd_pkg::OBA_W-1:0];
  end

  // Read data captured in setup, answered in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr <= rpd_pkg::OFF_STAT && paddr[1:0] == 2'h0);
      if (apb_rd)
        case (paddr)
          rpd_pkg::OFF_WORD1: prdata <= {16'h0000, code_reg};
          rpd_pkg::OFF_WORD2: prdata <= {16'h0000, conf_reg};
          rpd_pkg::OFF_WORD3: prdata <= {16'h0000, w3};
          rpd_pkg::OFF_WORD4: prdata <= {16'h0000, w4};
          rpd_pkg::OFF_CTRL: prdata <= {24'h000000, thresh_reg};
          rpd_pkg::OFF_STAT: prdata <= {29'h00000000, state_reg};
          default: prdata <= 32'h00000000;
        endcase
    end
  end

  // Checks
  ring_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
    run |-> $onehot(ring_reg)) else $error("ring not one-hot");
  shift_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    slot_tick && !data_reset |=> code_reg[0] == $past(bit_val))
    else $error("code bit not shifted");
  count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !slot_tick && !data_reset |=> $stable(count_reg)) else $error("count moved");
  ref_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == rpd_pkg::RPD_IDLE && init_pulse && !data_reset |=> ref_reg == $past(ref_value))
    else $error("reference not loaded");
  avg_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    slot_tick && bit_val && !first_slot_reg && !data_reset |=>
    avg_reg == rpd_pkg::OBA_W'(($past(avg_reg) + 9'($past(dly_slot.oba))) >> 1))
    else $error("average wrong");
  corr_thr_a: assert property (@(posedge pclk) disable iff (!presetn)
    own_corr |-> $past(diff_d <= thresh_reg)) else $error("bad correlation");
  ready_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    reply_ready |-> $past(state_reg == rpd_pkg::RPD_DONE)) else $error("early ready");
  reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_reset |=> !busy && count_reg == 4'h0 && ring_reg == 12'h000)
    else $error("data reset incomplete");
  hold_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == rpd_pkg::RPD_DONE && !data_reset |=> $stable(code_reg) && $stable(sum_reg))
    else $error("result changed");
  run_c: cover property (@(posedge pclk) disable iff (!presetn) run && slot_tick && bit_val);
  done_c: cover property (@(posedge pclk) disable iff (!presetn) reply_ready);
  corr_c: cover property (@(posedge pclk) disable iff (!presetn) own_corr && undly_corr);
endmodule

// ---- rpd_datapath_tb.sv ----
// Testbench for the reply decoder datapath: APB, replies, word readout.
// Assumes the controller model above and a 125 MHz pclk.
module rpd_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, start, data_reset, word_en, wsamp;
  logic ref_sel_last, ref_sidelobe, mil_ident, init_pulse, undly_pulse;
  logic pready, pslverr, own_corr, undly_corr, busy, reply_ready, phantom;
  logic [7:0] paddr, oba_val, undly_oba;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] pat, word_out;
  logic [1:0] word_sel;
  rpd_pkg::rpd_slot_type dly_slot;
  logic [63:0] q[$];
  logic [63:0] note;
  int errors, n_checks;
  rpd_datapath i_rpd_datapath (.pclk(pclk), .presetn(presetn), .paddr_dummy_unused_n(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .init_pulse(init_pulse),
    .ref_sel_last(ref_sel_last), .ref_sidelobe(ref_sidelobe), .mil_ident(mil_ident),
    .data_reset(data_reset), .dly_slot(dly_slot), .undly_oba(undly_oba),
    .undly_pulse(undly_pulse), .ref_value(oba_val), .other_garble(3'h0),
    .other_corr(3'h0), .last_code_slot(1'b0), .word_sel(word_sel), .word_en(word_en),
    .word_out(word_out), .own_corr(own_corr), .undly_corr(undly_corr), .busy(busy),
    .reply_ready(reply_ready), .last_code_phantom(phantom));
  rpd_ctrl_model i_rpd_ctrl_model (.pclk(pclk), .presetn(presetn), .start(start),
    .pat(pat), .oba_val(oba_val), .init_pulse(init_pulse), .dly_slot(dly_slot),
    .undly_pulse(undly_pulse), .undly_oba(undly_oba));
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Comparison under mask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] m);
    n_checks++;
    if ((seen & m) !== (exp & m))
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen & m, exp & m);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; a read notes its expectation as {mask, value}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [63:0] e, output logic err);
    if (!w)
      q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Select a word, then let the monitor take it one cycle later
  task automatic word(input logic [1:0] s, input logic [63:0] e);
    q.push_back(e);
    word_sel <= s;
    word_en <= 1'b1;
    @(posedge pclk);
    wsamp <= 1'b1;
    @(posedge pclk);
    wsamp <= 1'b0;
    word_en <= 1'b0;
    @(posedge pclk);
  endtask
  // Monitor: oldest note against each result that appears
  always @(posedge pclk)
  begin
    if ((psel && penable && pready && !pwrite) === 1'b1)
    begin
      note = q.pop_front();
      check(prdata, note[31:0], note[63:32]);
    end
    if (wsamp)
    begin
      note = q.pop_front();
      check({16'h0, word_out}, note[31:0], note[63:32]);
    end
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end
  initial
  begin
    logic err;
    logic [7:0] th;
    {psel, penable, pwrite, start, data_reset, word_en, wsamp} = '0;
    {ref_sel_last, ref_sidelobe, mil_ident} = '0;
    {paddr, pwdata, pat, word_sel, errors, n_checks} = '0;
    seed = 32'h6A8CFC3B;
    oba_val = 8'h40;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Registers: threshold reset, random write, unmapped place
    apb(1'b0, rpd_pkg::OFF_CTRL, 32'h0, {32'hFF, 32'h4}, err);
    seed = xs(seed);
    th = seed[7:0];
    apb(1'b1, rpd_pkg::OFF_CTRL, {24'h0, th}, '0, err);
    apb(1'b0, rpd_pkg::OFF_CTRL, 32'h0, {32'hFF, 24'h0, th}, err);
    apb(1'b0, 8'h18, 32'h0, 64'h0, err);
    check({31'h0, err}, 32'h1, 32'h1);
    $display("register test done");
    // Two replies: two counted ones, then a single one
    for (int r = 0; r < 2; r++)
    begin
      seed = xs(seed);
      oba_val <= seed[7:0];
      ref_sel_last <= r[0];
      ref_sidelobe <= ~r[0];
      mil_ident <= r[0];
      pat <= r ? 16'h0008 : 16'h000A;
      @(posedge pclk);
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      repeat (2) @(posedge pclk);
      check({31'h0, busy}, 32'h1, 32'h1);
      for (int i = 0; i < 4000 && reply_ready !== 1'b1; i++)
        @(posedge pclk);
      check({31'h0, reply_ready}, 32'h1, 32'h1);
      check({16'h0, word_out}, 32'h0, 32'hFFFF);
      word(2'h2, {32'hFFFF, 16'h0, 4'h0, ~r[0], r[0], ~r[0], r[0], oba_val});
      word(2'h3, {32'hFFFF, 16'h0, r ? 4'h1 : 4'h2,
        12'(oba_val) * (r ? 12'h002 : 12'h003)});
      data_reset <= 1'b1;
      @(posedge pclk);
      data_reset <= 1'b0;
      repeat (2) @(posedge pclk);
      check({30'h0, busy, reply_ready}, 32'h0, 32'h3);
      $display("reply test %0d done", r);
    end
    complete_run();
  end
endmodule

// ---- rpd_pkg.sv ----
// Package for the reply pulse decoder datapath: widths, timing counts, types.
// Assumes a 125 MHz pclk; APB slave for registers, one clock domain.
package rpd_pkg;
  // Clock and slot timing
  localparam int CLK_NS = 8;
  localparam int SLOT_NS = 1450;
  localparam int REPLY_NS = 24650;
  localparam int RING_STAGES = 12;
  // Cycles per pulse slot, rounded down, at least one
  localparam int SLOT_CYC = (SLOT_NS / CLK_NS) < 1 ? 1 : (SLOT_NS / CLK_NS);
  localparam int REPLY_CYC = REPLY_NS / CLK_NS;
  localparam int CODE_BITS = 16;
  localparam int OBA_W = 8;
  localparam int SUM_W = 12;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
  localparam int ZERO_WIN = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_WORD1 = 8'h00;
  localparam logic [7:0] OFF_WORD2 = 8'h04;
  localparam logic [7:0] OFF_WORD3 = 8'h08;
  localparam logic [7:0] OFF_WORD4 = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [OBA_W-1:0] THRESH_RST = 8'h04;
  // Word 3 field positions
  localparam int W3_EST_LSB = 0;
  localparam int W3_TYPE_BIT = 8;
  localparam int W3_BEAM_BIT = 9;
  localparam int W3_SEL_BIT = 10;
  localparam int W3_TWO_BIT = 11;
  // Pulse slot inputs from the controller
  typedef struct packed {
    logic pulse;
    logic sls;
    logic [OBA_W-1:0] oba;
  } rpd_slot_type;
  typedef enum logic [2:0] {
    RPD_IDLE = 3'b001,
    RPD_RUN = 3'b010,
    RPD_DONE = 3'b100
  } rpd_state_type;
endpackage
